// ==== logic/tmcr_pkg.sv ====
package tmcr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LOCAL_TEMP_ADDR = 8'h00;
  localparam logic [7:0] REMOTE_HI_ADDR = 8'h01;
  localparam logic [7:0] CFG_RD_ADDR = 8'h03;
  localparam logic [7:0] CFG_WR_ADDR = 8'h09;
  localparam logic [7:0] REMOTE_LO_ADDR = 8'h10;
  localparam int REG_COUNT = 22;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_PIN_SEL_BIT = 5;
  localparam int CFG_RANGE_BIT = 2;
  // Only these bits are stored; reserved bits read back as zero
  localparam logic [7:0] CFG_USED_MASK = 8'hE4;

  // ----------------------------------------------------------------
  // Result coding, in quarter degrees
  // ----------------------------------------------------------------
  localparam int RAW_W = 11;
  localparam logic [11:0] EXT_OFFSET_Q = 12'h100;
  localparam logic [11:0] DEF_MAX_Q = 12'h1FC;
  localparam logic [11:0] EXT_MAX_Q = 12'h3FF;
  localparam int LO_FRAC_BITS = 2;
endpackage

// ==== logic/tmcr_fmt_if.sv ====
`timescale 1ns/100ps
// Carries one raw result to the coder and the coded bytes back
interface tmcr_fmt_if;
  logic [tmcr_pkg::RAW_W-1:0] raw;
  logic ext;
  logic [7:0] hi;
  logic [7:0] lo;
  modport user (output raw, output ext, input hi, input lo);
  modport coder (input raw, input ext, output hi, output lo);
endinterface

// ==== logic/tmcr_fmt.sv ====
`timescale 1ns/100ps
module tmcr_fmt (
  tmcr_fmt_if.coder f
);
  // ----------------------------------------------------------------
  // Scale select and clamp
  // ----------------------------------------------------------------
  // Offset binary adds 64 degrees so the whole span stays positive
  wire logic signed [11:0] raw_sx = {f.raw[tmcr_pkg::RAW_W-1], f.raw};
  wire logic signed [11:0] biased = f.ext ?
    raw_sx + $signed(tmcr_pkg::EXT_OFFSET_Q) : raw_sx;
  wire logic [11:0] top_q = f.ext ? tmcr_pkg::EXT_MAX_Q :
    tmcr_pkg::DEF_MAX_Q;
  wire logic below = biased < 0;
  wire logic above = !below && ($unsigned(biased) > top_q);
  // Clamping in the default scale returns 0 or 127 whole degrees
  wire logic [11:0] coded = below ? 12'h000 :
    above ? top_q : $unsigned(biased);
  assign f.hi = coded[9:2];
  // Low byte is left justified, six lower bits always zero
  assign f.lo = {coded[1:0], 6'h00};
endmodule

// ==== logic/tmcr_regs.sv ====
`timescale 1ns/100ps
// How it works
// - Configuration bit 2 selects default or extended range
// - First result after range change needs a new conversion start
// - Extended registers cover -64 to +191 degrees
// - Shorted remote diode keeps last good result
// - Binary by default, offset-64 binary when extended
// - Default range clamps negative readings to zero
// - Default range clamps readings above 127 to 127
// - Range switch changes format; limits are untouched
// - Twenty-two eight-bit registers in the map
// - First write byte loads the address pointer
// - Second byte writes pointed register; else reads
// - Pointer resets to zero, selecting local temperature
// - Temperature registers converter-written, read-only, reset zero
// - Config read at one address, written another
// - Alert mask bit gates alert, not second overtemp
// - Standby bit stops conversions when set
// - Register access continues normally during standby
// - Pin outputs stay live and follow writes
// - Pin function bit picks alert or second overtemp
// - Remote low byte holds two fraction bits
module tmcr_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic smb_wr_valid,
  input wire logic smb_wr_first,
  input wire logic [7:0] smb_wr_data,
  input wire logic smb_rd_req,
  output logic [7:0] smb_rd_data,
  output logic smb_rd_valid,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic conv_remote,
  input wire logic conv_short,
  input wire logic [tmcr_pkg::RAW_W-1:0] conv_temp,
  input wire logic alert_req,
  input wire logic overtemp_comparator_output_req,
  input wire logic second_overtemp_output_req,
  output logic conv_run,
  output logic range_ext,
  output logic pin6_o,
  output logic pin6_oe,
  output logic overtemp_comparator_output_o,
  output logic overtemp_comparator_output_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] local_reg;
  logic [7:0] local_next;
  logic [7:0] rhi_reg;
  logic [7:0] rhi_next;
  logic [7:0] rlo_reg;
  logic [7:0] rlo_next;
  logic stale_reg;
  logic stale_next;
  logic [7:0] rd_data_next;

  tmcr_fmt_if fmt ();

  tmcr_fmt u_fmt (
    .f(fmt)
  );

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------
  // Byte after the first goes to whatever the pointer names
  wire logic ptr_load = smb_wr_valid && smb_wr_first;
  wire logic data_wr = smb_wr_valid && !smb_wr_first;
  // Only the write alias of the configuration is writable
  wire logic cfg_wr = data_wr && (ptr_reg == tmcr_pkg::CFG_WR_ADDR);

  // Pointer is only touched by a first byte, otherwise kept
  assign ptr_next = ptr_load ? smb_wr_data : ptr_reg;
  // Reserved bits are dropped so they always read as zero
  assign cfg_next = cfg_wr ?
    (smb_wr_data & tmcr_pkg::CFG_USED_MASK) : cfg_reg;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire logic cfg_mask = cfg_reg[tmcr_pkg::CFG_MASK_BIT];
  wire logic cfg_standby = cfg_reg[tmcr_pkg::CFG_STANDBY_BIT];
  wire logic cfg_pin_sel = cfg_reg[tmcr_pkg::CFG_PIN_SEL_BIT];
  wire logic cfg_range = cfg_reg[tmcr_pkg::CFG_RANGE_BIT];

  assign range_ext = cfg_range;
  // Standby halts the converter but not the register access
  assign conv_run = !cfg_standby;

  // ----------------------------------------------------------------
  // Shared pin and overtemp pin, open drain
  // ----------------------------------------------------------------
  // Combinational so a write in standby is seen at once
  wire logic alert_drive = alert_req && !cfg_mask;
  assign pin6_oe = cfg_pin_sel ? second_overtemp_output_req : alert_drive;
  assign pin6_o = 1'b0;
  assign overtemp_comparator_output_oe = overtemp_comparator_output_req;
  assign overtemp_comparator_output_o = 1'b0;

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  // A change of range marks the running conversion stale; its
  // result mixes scales, so it is thrown away until a new one
  // starts. Costs one conversion of latency, never a bad code.
  wire logic range_flip = cfg_wr &&
    (smb_wr_data[tmcr_pkg::CFG_RANGE_BIT] != cfg_range);
  assign stale_next = range_flip ? 1'b1 :
    (conv_start ? 1'b0 : stale_reg);

  wire logic result_ok = conv_done && !stale_reg && !cfg_standby;
  wire logic local_upd = result_ok && !conv_remote;
  // A shorted diode would produce junk; last good value stays
  wire logic remote_upd = result_ok && conv_remote && !conv_short;

  // The coder always works in the currently selected scale
  assign fmt.raw = conv_temp;
  assign fmt.ext = cfg_range;

  assign local_next = local_upd ? fmt.hi : local_reg;
  assign rhi_next = remote_upd ? fmt.hi : rhi_reg;
  assign rlo_next = remote_upd ? fmt.lo : rlo_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Other registers of the map live in neighbouring blocks; any
  // address not held here answers with zero
  assign rd_data_next =
    (ptr_reg == tmcr_pkg::LOCAL_TEMP_ADDR) ? local_reg :
    (ptr_reg == tmcr_pkg::REMOTE_HI_ADDR) ? rhi_reg :
    (ptr_reg == tmcr_pkg::REMOTE_LO_ADDR) ? rlo_reg :
    (ptr_reg == tmcr_pkg::CFG_RD_ADDR) ? cfg_reg :
    tmcr_pkg::UNMAPPED_READ;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pointer and configuration
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ptr_reg <= tmcr_pkg::PTR_RESET;
      cfg_reg <= tmcr_pkg::CFG_RESET;
      stale_reg <= 1'b0;
    end else if (ce) begin
      ptr_reg <= ptr_next;
      cfg_reg <= cfg_next;
      stale_reg <= stale_next;
    end
  end

  // Temperature values, written only by the converter side
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      local_reg <= tmcr_pkg::TEMP_RESET;
      rhi_reg <= tmcr_pkg::TEMP_RESET;
      rlo_reg <= tmcr_pkg::TEMP_RESET;
    end else if (ce) begin
      local_reg <= local_next;
      rhi_reg <= rhi_next;
      rlo_reg <= rlo_next;
    end
  end

  // Read answer one cycle after the request, standby or not
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      smb_rd_data <= 8'h00;
      smb_rd_valid <= 1'b0;
    end else if (ce) begin
      smb_rd_valid <= smb_rd_req;
      if (smb_rd_req) begin
        smb_rd_data <= rd_data_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_first_byte;
    ce && ptr_load;
  endsequence

  property p_ptr_load;
    @(posedge mclk) disable iff (reset)
    s_first_byte |=> ptr_reg == $past(smb_wr_data);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded by first write byte");

  property p_ptr_hold;
    @(posedge mclk) disable iff (reset)
    !ptr_load |=> ptr_reg == $past(ptr_reg);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer changed without a first byte");

  sequence s_cfg_write;
    ce && data_wr && ptr_reg == tmcr_pkg::CFG_WR_ADDR;
  endsequence

  property p_cfg_write;
    @(posedge mclk) disable iff (reset)
    s_cfg_write |=>
      cfg_reg == ($past(smb_wr_data) & tmcr_pkg::CFG_USED_MASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write not stored");

  property p_read_answer;
    @(posedge mclk) disable iff (reset)
    ce && smb_rd_req |=> smb_rd_valid &&
      smb_rd_data == $past(rd_data_next);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered next cycle");

  property p_short_hold;
    @(posedge mclk) disable iff (reset)
    conv_done && conv_remote && conv_short && !data_wr |=>
      rhi_reg == $past(rhi_reg) && rlo_reg == $past(rlo_reg);
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("shorted diode overwrote remote value");

  // A result landing while the flag is up must leave the local and remote high values unchanged
  sequence s_stale_result;
    ce && stale_reg && conv_done;
  endsequence

  property p_stale_drop;
    @(posedge mclk) disable iff (reset)
    s_stale_result |=>
      local_reg == $past(local_reg) && rhi_reg == $past(rhi_reg);
  endproperty
  a_stale_drop: assert property (p_stale_drop)
    else $error("stale result stored after range change");

  sequence s_range_flip;
    ce && range_flip;
  endsequence

  property p_stale_set;
    @(posedge mclk) disable iff (reset)
    s_range_flip |=> stale_reg;
  endproperty
  a_stale_set: assert property (p_stale_set)
    else $error("range change did not hold off results");

  // Flip wins over a start in the same cycle
  property p_stale_clear;
    @(posedge mclk) disable iff (reset)
    ce && conv_start && !range_flip |=> !stale_reg;
  endproperty
  a_stale_clear: assert property (p_stale_clear)
    else $error("new conversion did not clear the hold-off");

  property p_default_clamp;
    @(posedge mclk) disable iff (reset)
    ce && local_upd && !cfg_range |=> local_reg[7] == 1'b0 &&
      (!$past(conv_temp[tmcr_pkg::RAW_W-1]) || local_reg == 8'h00);
  endproperty
  a_default_clamp: assert property (p_default_clamp)
    else $error("default range value outside 0 to 127");

  // In-range default values pass through as plain whole degrees
  property p_default_code;
    @(posedge mclk) disable iff (reset)
    ce && local_upd && !cfg_range && !conv_temp[tmcr_pkg::RAW_W-1] &&
      ($unsigned(conv_temp) <= tmcr_pkg::DEF_MAX_Q) |=>
      local_reg == $past(conv_temp[9:2]);
  endproperty
  a_default_code: assert property (p_default_code)
    else $error("default range value not plain binary");

  // Extended values carry the 64 degree offset
  property p_ext_code;
    @(posedge mclk) disable iff (reset)
    ce && local_upd && cfg_range && !conv_temp[tmcr_pkg::RAW_W-1] &&
      ({1'b0, conv_temp} + tmcr_pkg::EXT_OFFSET_Q <= tmcr_pkg::EXT_MAX_Q)
      |=> local_reg ==
      $past(conv_temp[9:2]) + tmcr_pkg::EXT_OFFSET_Q[9:2];
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("extended value not offset binary");

  property p_low_byte;
    @(posedge mclk) disable iff (reset)
    rlo_reg[5:0] == 6'h00;
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("remote low byte has unused bits set");

  property p_pin6;
    @(posedge mclk) disable iff (reset)
    pin6_oe == (cfg_pin_sel ? second_overtemp_output_req : (alert_req && !cfg_mask));
  endproperty
  a_pin6: assert property (p_pin6)
    else $error("shared pin drive wrong for its function");

  property p_standby;
    @(posedge mclk) disable iff (reset)
    conv_run != cfg_reg[tmcr_pkg::CFG_STANDBY_BIT];
  endproperty
  a_standby: assert property (p_standby)
    else $error("converter run not following standby bit");

  // Overtemp pin follows its request at once, standby or not
  property p_overtemp_comparator_output;
    @(posedge mclk) disable iff (reset)
    overtemp_comparator_output_oe == overtemp_comparator_output_req && !overtemp_comparator_output_o && !pin6_o;
  endproperty
  a_overtemp_comparator_output: assert property (p_overtemp_comparator_output)
    else $error("overtemp pin not following its request");

  property p_range_out;
    @(posedge mclk) disable iff (reset)
    range_ext == cfg_reg[tmcr_pkg::CFG_RANGE_BIT];
  endproperty
  a_range_out: assert property (p_range_out)
    else $error("range output not following range bit");

  // Settings change only through the write alias
  property p_cfg_hold;
    @(posedge mclk) disable iff (reset)
    !(ce && cfg_wr) |=> cfg_reg == $past(cfg_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed without a write");

  // Host bytes never reach the value registers
  property p_temps_ro;
    @(posedge mclk) disable iff (reset)
    ce && data_wr && !conv_done |=> local_reg == $past(local_reg) &&
      rhi_reg == $past(rhi_reg) && rlo_reg == $past(rlo_reg);
  endproperty
  a_temps_ro: assert property (p_temps_ro)
    else $error("host write reached a value register");

  property p_standby_drop;
    @(posedge mclk) disable iff (reset)
    ce && conv_done && cfg_standby |=> local_reg == $past(local_reg) &&
      rhi_reg == $past(rhi_reg) && rlo_reg == $past(rlo_reg);
  endproperty
  a_standby_drop: assert property (p_standby_drop)
    else $error("result stored during standby");
endmodule

// ==== tb/tmcr_host_model.sv ====
`timescale 1ns/100ps
// SMBus host controller seen as byte requests to the register file
module tmcr_host_model (
  input wire logic mclk,
  input wire logic [7:0] smb_rd_data,
  input wire logic smb_rd_valid,
  output logic smb_wr_valid,
  output logic smb_wr_first,
  output logic [7:0] smb_wr_data,
  output logic smb_rd_req
);
  // Idle bus; data shows the inverse of the last byte when released
  initial begin
    smb_wr_valid = 1'b0;
    smb_wr_first = 1'b0;
    smb_wr_data = 8'h00;
    smb_rd_req = 1'b0;
  end

  // Pointer byte alone, as a write with no payload
  task set_ptr(input logic [7:0] a);
    @(posedge mclk);
    smb_wr_valid <= 1'b1;
    smb_wr_first <= 1'b1;
    smb_wr_data <= a;
    @(posedge mclk);
    smb_wr_valid <= 1'b0;
    smb_wr_data <= ~a;
  endtask

  // Pointer then data, back to back; callers keep reserved bits clear
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    smb_wr_valid <= 1'b1;
    smb_wr_first <= 1'b1;
    smb_wr_data <= a;
    @(posedge mclk);
    smb_wr_first <= 1'b0;
    smb_wr_data <= d;
    @(posedge mclk);
    smb_wr_valid <= 1'b0;
    smb_wr_data <= ~d;
  endtask

  // Read at the pointer; answer is due one edge after the request
  task rd(output logic [7:0] d);
    @(posedge mclk);
    smb_rd_req <= 1'b1;
    @(posedge mclk);
    smb_rd_req <= 1'b0;
    @(negedge mclk);
    d = (smb_rd_valid === 1'b1) ? smb_rd_data : 8'hXX;
  endtask
endmodule

// ==== tb/temp_monitor_config_regs_tb_top.sv ====
`timescale 1ns/100ps
module temp_monitor_config_regs_tb_top;
  logic mclk, reset, ce, conv_start, conv_done, conv_remote, conv_short;
  logic alert_req, overtemp_comparator_output_req, second_overtemp_output_req;
  logic [tmcr_pkg::RAW_W-1:0] conv_temp;
  logic wr_valid, wr_first, rd_req, rd_valid;
  logic [7:0] wr_data, rd_data, d;
  logic conv_run, range_ext, pin6_o, pin6_oe, overtemp_comparator_output_o, overtemp_comparator_output_oe;
  int errors = 0;
  int total_checks = 0;

  tmcr_regs i_dut (.mclk(mclk), .reset(reset), .ce(ce),
    .smb_wr_valid(wr_valid), .smb_wr_first(wr_first),
    .smb_wr_data(wr_data), .smb_rd_req(rd_req), .smb_rd_data(rd_data),
    .smb_rd_valid(rd_valid), .conv_start(conv_start),
    .conv_done(conv_done), .conv_remote(conv_remote),
    .conv_short(conv_short), .conv_temp(conv_temp),
    .alert_req(alert_req), .overtemp_comparator_output_req(overtemp_comparator_output_req),
    .second_overtemp_output_req(second_overtemp_output_req), .conv_run(conv_run), .range_ext(range_ext),
    .pin6_o(pin6_o), .pin6_oe(pin6_oe), .overtemp_comparator_output_o(overtemp_comparator_output_o),
    .overtemp_comparator_output_oe(overtemp_comparator_output_oe));
  tmcr_host_model i_host (.mclk(mclk), .smb_rd_data(rd_data),
    .smb_rd_valid(rd_valid), .smb_wr_valid(wr_valid),
    .smb_wr_first(wr_first), .smb_wr_data(wr_data), .smb_rd_req(rd_req));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.set_ptr(a);
    i_host.rd(d);
    chk(d, exp);
  endtask

  // Pin and mode outputs packed: pin6_oe, overtemp_comparator_output_oe, conv_run, range_ext
  task pins_chk(input logic [7:0] exp);
    @(negedge mclk);
    chk({pin6_o, overtemp_comparator_output_o, 2'h0, pin6_oe, overtemp_comparator_output_oe, conv_run, range_ext},
      exp);
  endtask

  task conv(input logic r, input logic s, input logic [10:0] t);
    @(posedge mclk);
    conv_done <= 1'b1;
    conv_remote <= r;
    conv_short <= s;
    conv_temp <= t;
    @(posedge mclk);
    conv_done <= 1'b0;
    conv_temp <= ~t;
  endtask

  task start;
    @(posedge mclk);
    conv_start <= 1'b1;
    @(posedge mclk);
    conv_start <= 1'b0;
  endtask

  task set_req(input logic a, input logic t, input logic t2);
    @(posedge mclk);
    alert_req <= a;
    overtemp_comparator_output_req <= t;
    second_overtemp_output_req <= t2;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    i_host.rd(d);
    chk(d, 8'h00);
    pins_chk(8'h02);
    rdchk(8'h03, 8'h00);
    rdchk(8'h10, 8'h00);
    $display("test reset done");
  endtask

  // Remote 25.75 degrees splits into 0x19 and 0xC0
  task t_format;
    conv(1'b0, 1'b0, 11'h028);
    rdchk(8'h00, 8'h0A);
    i_host.rd(d);
    chk(d, 8'h0A);
    conv(1'b0, 1'b0, 11'h7FC);
    rdchk(8'h00, 8'h00);
    conv(1'b0, 1'b0, 11'h320);
    rdchk(8'h00, 8'h7F);
    conv(1'b1, 1'b0, 11'h067);
    rdchk(8'h01, 8'h19);
    rdchk(8'h10, 8'hC0);
    conv(1'b1, 1'b1, 11'h100);
    rdchk(8'h01, 8'h19);
    i_host.wr_reg(8'h00, 8'h55);
    rdchk(8'h00, 8'h7F);
    rdchk(8'hFE, 8'h00);
    $display("test format done");
  endtask

  // Results before the next cycle start are stale and must be dropped
  task t_range;
    i_host.wr_reg(8'h09, 8'h04);
    pins_chk(8'h03);
    rdchk(8'h03, 8'h04);
    // Host restates a 10 degree limit, held elsewhere, in the new format
    i_host.wr_reg(8'h20, 8'h4A);
    rdchk(8'h20, 8'h00);
    conv(1'b0, 1'b0, 11'h028);
    rdchk(8'h00, 8'h7F);
    start();
    conv(1'b0, 1'b0, 11'h028);
    rdchk(8'h00, 8'h4A);
    conv(1'b0, 1'b0, 11'h700);
    rdchk(8'h00, 8'h00);
    conv(1'b1, 1'b0, 11'h2FF);
    rdchk(8'h01, 8'hFF);
    i_host.wr_reg(8'h09, 8'h00);
    start();
    conv(1'b0, 1'b0, 11'h028);
    rdchk(8'h00, 8'h0A);
    $display("test range done");
  endtask

  task t_pins;
    set_req(1'b1, 1'b0, 1'b0);
    pins_chk(8'h0A);
    i_host.wr_reg(8'h09, 8'h80);
    pins_chk(8'h02);
    i_host.wr_reg(8'h09, 8'hA0);
    set_req(1'b1, 1'b0, 1'b1);
    pins_chk(8'h0A);
    set_req(1'b1, 1'b0, 1'b0);
    pins_chk(8'h02);
    i_host.wr_reg(8'h09, 8'h40);
    set_req(1'b1, 1'b1, 1'b0);
    pins_chk(8'h0C);
    conv(1'b0, 1'b0, 11'h040);
    rdchk(8'h03, 8'h40);
    rdchk(8'h00, 8'h0A);
    i_host.wr_reg(8'h09, 8'hC0);
    pins_chk(8'h04);
    $display("test pins done");
  endtask

  // Reset in mid-run: pointer, settings and stored values all drop
  task t_reset_again;
    i_host.set_ptr(8'h01);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    pins_chk(8'h0E);
    // A fresh local value tells a reset pointer from a kept one
    conv(1'b0, 1'b0, 11'h028);
    i_host.rd(d);
    chk(d, 8'h0A);
    rdchk(8'h01, 8'h00);
    $display("test reset again done");
  endtask

  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    test_done();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {conv_start, conv_done, conv_remote, conv_short} = 4'h0;
    {alert_req, overtemp_comparator_output_req, second_overtemp_output_req} = 3'h0;
    conv_temp = 11'h000;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_format();
    t_range();
    t_pins();
    t_reset_again();
    test_done();
  end
endmodule
